// ---- include/oss_regs.vh ----
/*
 * constants for the ook slicer and bit synchronizer: apb register map,
 * field positions, reset values and mode codes.
 * assumes a 32-bit apb master and the 25 MHz system clock.
 */
// Operation
// RL1 - slice strength against peak, fixed or average threshold
// RL2 - peak mode threshold is peak minus 6 dB
// RL3 - peak decays one step per period on zero
// RL4 - decaying peak clamps at floor level
// RL5 - period code sets decrement rate per chip
// RL6 - step code sets decrement size 0.5 to 6 dB
// RL7 - fixed mode slices against floor level
// RL8 - average mode low-passes strength, cutoff selectable
// RL9 - sync bypassed when disabled and irq1 low
// RL10 - continuous mode outputs recovered clock on irq1; code drives irq1 only while clock_recovery_disable is 0
// RL11 - buffered or packet mode forces sync on
// RL12 - bit rate is clock over 64 times divider+1
// RL13 - transmitter sends three preamble bytes first; code has no transmit path, the transmit state only turns receive off
// RL14 - clock rising edge centred, realign on transitions
// RL15 - matched rates hold lock over long runs
// RL16 - continuous mode drives bits on data pin
// RL17 - buffered and packet modes route bits to fifo
// RL18 - state select: sleep, standby, synth, receive, transmit
// RL19 - receive chain enabled only in receive state
// RL20 - host programs deviation 00000011 for ook
// RL21 - host matches deviation to incoming fsk
// RL22 - fsk polarity from i/q phase, sync or raw
// RL23 - strength is sliding 16-sample average
// RL24 - path select: continuous, buffered, packet
// RL25 - sample above peak loads immediately as peak
`ifndef OSS_REGS_VH
`define OSS_REGS_VH
// register byte addresses
`define OSS_ADDR_STATE 12'h000
`define OSS_ADDR_SLICE 12'h004
`define OSS_ADDR_RATE 12'h008
`define OSS_ADDR_STATUS 12'h00C
// state register fields
`define OSS_STATE_LSB 0
`define OSS_PATH_LSB 4
`define OSS_DEV_LSB 8
`define OSS_CRD_BIT 16
// slice register fields
`define OSS_TYPE_LSB 0
`define OSS_STEP_LSB 4
`define OSS_PER_LSB 8
`define OSS_CUT_LSB 12
`define OSS_FLOOR_LSB 16
// reset values
`define OSS_STATE_RST 3'h1
`define OSS_DEV_RST 8'h03
`define OSS_FLOOR_RST 8'h0C
`define OSS_BR_RST 8'h07
// operating states
`define OSS_ST_SLEEP 3'h0
`define OSS_ST_STBY 3'h1
`define OSS_ST_SYNTH 3'h2
`define OSS_ST_RX 3'h3
`define OSS_ST_TX 3'h4
// threshold types
`define OSS_THR_PEAK 2'h0
`define OSS_THR_FIXED 2'h1
`define OSS_THR_AVG 2'h2
// 6 dB in half-dB units
`define OSS_PEAK_OFS 8'h0C
// strength window, and divider base of 64 clocks
`define OSS_AVG_LOG 4
`define OSS_BR_BASE 6
`endif

// ---- rtl/oss_top.v ----
/*
 * ook slicer, peak/fixed/average threshold, bit synchronizer and
 * operating-state select with an apb register slave.
 * assumes strength samples in 0.5 dB units arrive on clk with a
 * one-cycle valid, and irq1 pin level is asynchronous.
 */
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "oss_regs.vh"
module oss_top #(
    parameter SW = 8
) (
    input wire clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [SW-1:0] sample_in,
    input wire sample_valid,
    input wire fsk_bit_in,
    input wire irq1_pin_in,
    output reg data_pin_out,
    output reg data_pin_oe,
    output reg irq1_pin_out,
    output reg irq1_pin_oe,
    output reg fifo_bit,
    output reg fifo_bit_valid,
    output reg rx_chain_enable
);
    reg [2:0] operating_state_select;
    reg [1:0] data_path_select;
    reg [7:0] deviation_setting;
    reg clock_recovery_disable;
    reg [1:0] slicer_threshold_type;
    reg [2:0] peak_decay_step;
    reg [2:0] peak_decay_period;
    reg [1:0] average_filter_cutoff;
    reg [SW-1:0] slicer_floor_level;
    reg [7:0] bit_rate_divider;
    reg ook_mode;
    reg [1:0] irq1_sync;
    reg [SW+`OSS_AVG_LOG-1:0] win_sum;
    reg [SW-1:0] win_mem [0:15];
    reg [3:0] win_ptr;
    reg [SW-1:0] signal_strength_value;
    reg [SW-1:0] peak;
    reg [SW+5:0] avg_acc;
    reg [SW-1:0] threshold;
    reg slice_bit;
    reg [14:0] chip_cnt;
    reg [3:0] sub_cnt;
    reg [14:0] ph_cnt;
    reg last_in;
    reg sync_bit;
    reg recovered_data_clock;
    reg recovered_data_clock_d;
    wire apb_wr = psel & penable & pwrite;
    wire apb_rd = psel & penable & ~pwrite;
    wire rx_on = (operating_state_select == `OSS_ST_RX);
    wire cont_mode = (data_path_select == 2'h0);
    // divider 0xFF needs the 15th bit: 256 * 64 clocks
    wire [14:0] bit_period = {{1'b0, bit_rate_divider} + 9'h001, 6'h00};
    wire [14:0] half_period = {1'b0, bit_period[14:1]};
    wire raw_bit = ook_mode ? slice_bit : fsk_bit_in; // [RL22]
    wire sync_on = ~cont_mode | ~clock_recovery_disable | irq1_sync[1]; // [RL9] [RL11]
    wire [SW:0] peak_less = {1'b0, peak} - {1'b0, slicer_floor_level};
    // running window sum and filter output, cut on purpose
    wire [SW+`OSS_AVG_LOG-1:0] win_next = win_sum + sample_in - win_mem[win_ptr];
    wire [SW+5:0] avg_shift = avg_acc >> ({1'b0, average_filter_cutoff} + 3'h3);
    reg [SW-1:0] step_size;
    reg decay_tick;
    reg [14:0] chip_len;

    // apb slave, zero wait states, unmapped reads zero and error
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            operating_state_select <= `OSS_STATE_RST;
            data_path_select <= 2'h0;
            deviation_setting <= `OSS_DEV_RST;
            clock_recovery_disable <= 1'b0;
            slicer_threshold_type <= `OSS_THR_PEAK;
            peak_decay_step <= 3'h0;
            peak_decay_period <= 3'h0;
            average_filter_cutoff <= 2'h0;
            slicer_floor_level <= `OSS_FLOOR_RST;
            bit_rate_divider <= `OSS_BR_RST;
            ook_mode <= 1'b1;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                if (paddr == `OSS_ADDR_STATE) begin
                    prdata <= {15'h0000, clock_recovery_disable, deviation_setting, 2'h0, data_path_select,
                        1'b0, operating_state_select};
                end else if (paddr == `OSS_ADDR_SLICE) begin
                    prdata <= {{(16-SW){1'b0}}, slicer_floor_level, 2'h0, average_filter_cutoff,
                        1'b0, peak_decay_period, 1'b0, peak_decay_step, ook_mode, 1'b0, slicer_threshold_type};
                end else if (paddr == `OSS_ADDR_RATE) begin
                    prdata <= {24'h000000, bit_rate_divider};
                end else if (paddr == `OSS_ADDR_STATUS) begin
                    prdata <= {{(16-SW){1'b0}}, threshold, {(16-SW){1'b0}}, signal_strength_value};
                end else begin
                    prdata <= 32'h00000000;
                    pslverr <= 1'b1;
                end
                if (pwrite) begin
                    prdata <= 32'h00000000;
                end
            end
            if (apb_wr && paddr == `OSS_ADDR_STATE) begin
                operating_state_select <= pwdata[`OSS_STATE_LSB+2:`OSS_STATE_LSB]; // [RL18]
                data_path_select <= pwdata[`OSS_PATH_LSB+1:`OSS_PATH_LSB]; // [RL24]
                deviation_setting <= pwdata[`OSS_DEV_LSB+7:`OSS_DEV_LSB];
                clock_recovery_disable <= pwdata[`OSS_CRD_BIT];
            end
            if (apb_wr && paddr == `OSS_ADDR_SLICE) begin
                slicer_threshold_type <= pwdata[`OSS_TYPE_LSB+1:`OSS_TYPE_LSB];
                ook_mode <= pwdata[`OSS_TYPE_LSB+3];
                peak_decay_step <= pwdata[`OSS_STEP_LSB+2:`OSS_STEP_LSB];
                peak_decay_period <= pwdata[`OSS_PER_LSB+2:`OSS_PER_LSB];
                average_filter_cutoff <= pwdata[`OSS_CUT_LSB+1:`OSS_CUT_LSB];
                slicer_floor_level <= pwdata[`OSS_FLOOR_LSB+SW-1:`OSS_FLOOR_LSB];
            end
            if (apb_wr && paddr == `OSS_ADDR_RATE) begin
                bit_rate_divider <= pwdata[7:0];
            end
        end
    end

    // irq1 pin level synchroniser
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq1_sync <= 2'h0;
        end else begin
            irq1_sync <= {irq1_sync[0], irq1_pin_in};
        end
    end

    // step size in half-dB units and decrement tick from period code
    always @* begin
        step_size = {SW{1'b0}};
        case (peak_decay_step) // [RL6]
            3'h0: step_size[3:0] = 4'h1;
            3'h1: step_size[3:0] = 4'h2;
            3'h2: step_size[3:0] = 4'h3;
            3'h3: step_size[3:0] = 4'h4;
            3'h4: step_size[3:0] = 4'h6;
            3'h5: step_size[3:0] = 4'h8;
            3'h6: step_size[3:0] = 4'hA;
            default: step_size[3:0] = 4'hC;
        endcase
        chip_len = peak_decay_period[2] ? (bit_period >> ({1'b0, peak_decay_period[1:0]} + 3'h1)) : bit_period;
        decay_tick = 1'b0;
        if (peak_decay_period[2]) begin
            decay_tick = (chip_cnt == chip_len - 15'h0001); // [RL5]
        end else begin
            decay_tick = (chip_cnt == bit_period - 15'h0001) && ((sub_cnt & ((4'h1 << peak_decay_period[1:0])
                - 4'h1)) == 4'h0); // [RL5]
        end
    end

    // sliding window of 16 strength samples
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            win_sum <= {(SW+`OSS_AVG_LOG){1'b0}};
            win_ptr <= 4'h0;
            signal_strength_value <= {SW{1'b0}};
        end else if (rx_on && sample_valid) begin
            win_sum <= win_next; // [RL23]
            win_ptr <= win_ptr + 4'h1;
            signal_strength_value <= win_next[SW+`OSS_AVG_LOG-1:`OSS_AVG_LOG]; // [RL23]
        end
    end

    // window memory, cleared at reset one entry per generate
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_win
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    win_mem[gi] <= {SW{1'b0}};
                end else if (rx_on && sample_valid && win_ptr == gi) begin
                    win_mem[gi] <= sample_in;
                end
            end
        end
    endgenerate

    // peak tracker with decay clamped at floor, and average filter
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            peak <= {SW{1'b0}};
            avg_acc <= {(SW+6){1'b0}};
        end else if (!rx_on) begin
            peak <= slicer_floor_level;
        end else begin
            if (signal_strength_value > peak) begin
                peak <= signal_strength_value; // [RL25]
            end else if (decay_tick && !slice_bit) begin
                if (peak_less > {1'b0, step_size}) begin
                    peak <= peak - step_size; // [RL3]
                end else begin
                    peak <= slicer_floor_level; // [RL4]
                end
            end
            if (sample_valid) begin
                avg_acc <= avg_acc + signal_strength_value - avg_shift; // [RL8]
            end
        end
    end

    // threshold select and comparator
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            threshold <= {SW{1'b0}};
            slice_bit <= 1'b0;
        end else begin
            case (slicer_threshold_type) // [RL1]
                `OSS_THR_PEAK: threshold <= ({1'b0, peak} > {1'b0, slicer_floor_level} + {1'b0, `OSS_PEAK_OFS}) ?
                    peak - `OSS_PEAK_OFS : slicer_floor_level; // [RL2] [RL4]
                `OSS_THR_FIXED: threshold <= slicer_floor_level; // [RL7]
                default: threshold <= avg_shift[SW-1:0]; // [RL8]
            endcase
            slice_bit <= rx_on && (signal_strength_value > threshold); // [RL1]
        end
    end

    // bit clock: free-running period counter, realigned on transitions
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chip_cnt <= 15'h0000;
            sub_cnt <= 4'h0;
            ph_cnt <= 15'h0000;
            last_in <= 1'b0;
            sync_bit <= 1'b0;
            recovered_data_clock <= 1'b0;
            recovered_data_clock_d <= 1'b0;
        end else begin
            chip_cnt <= (chip_cnt >= chip_len - 15'h0001) ? 15'h0000 : chip_cnt + 15'h0001;
            if (chip_cnt == bit_period - 15'h0001) begin
                sub_cnt <= sub_cnt + 4'h1;
            end
            last_in <= raw_bit;
            recovered_data_clock_d <= recovered_data_clock;
            if (raw_bit != last_in) begin
                ph_cnt <= 15'h0000; // [RL14]
            end else if (ph_cnt >= bit_period - 15'h0001) begin
                ph_cnt <= 15'h0000; // [RL15]
            end else begin
                ph_cnt <= ph_cnt + 15'h0001; // [RL12]
            end
            recovered_data_clock <= rx_on && (ph_cnt >= half_period); // [RL14]
            if (ph_cnt == half_period) begin
                sync_bit <= raw_bit; // [RL14]
            end
        end
    end

    // output routing per data path
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_pin_out <= 1'b0;
            data_pin_oe <= 1'b0;
            irq1_pin_out <= 1'b0;
            irq1_pin_oe <= 1'b0;
            fifo_bit <= 1'b0;
            fifo_bit_valid <= 1'b0;
            rx_chain_enable <= 1'b0;
        end else begin
            rx_chain_enable <= rx_on; // [RL19]
            data_pin_oe <= rx_on && cont_mode; // [RL16]
            data_pin_out <= rx_on && cont_mode && (sync_on ? sync_bit : raw_bit); // [RL9] [RL22]
            // clock pin only when sync is not disabled, so its own low half cannot look like a host hold
            irq1_pin_oe <= rx_on && cont_mode && !clock_recovery_disable; // [RL10]
            irq1_pin_out <= rx_on && cont_mode && !clock_recovery_disable && recovered_data_clock; // [RL10]
            fifo_bit <= sync_bit; // [RL11]
            fifo_bit_valid <= rx_on && !cont_mode && recovered_data_clock && !recovered_data_clock_d; // [RL17]
        end
    end
endmodule // oss_top

// ---- sim/oss_props.sv ----
/* port checker for the ook slicer and bit synchronizer.
   assumes it is bound to oss_top and sees only its ports. */
`timescale 1ns/1ns
`include "oss_regs.vh"
module oss_props (
    input wire clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire data_pin_oe,
    input wire irq1_pin_oe,
    input wire fifo_bit_valid,
    input wire rx_chain_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // apb setup cycle and an accepted state write
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence st_wr_s;
        psel && penable && pready && pwrite && paddr == `OSS_ADDR_STATE;
    endsequence
    // bus answers and state decode
    ready_next_a: assert property (setup_s |=> pready) else $error("no pready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    rx_on_a: assert property (st_wr_s ##0 pwdata[2:0] == 3'h3 |-> ##[1:2] rx_chain_enable)
        else $error("receive chain not enabled");
    rx_off_a: assert property (st_wr_s ##0 pwdata[2:0] != 3'h3 |-> ##[1:2] !rx_chain_enable)
        else $error("receive chain enabled outside receive");
    // pins and data routing
    pin_rx_a: assert property (data_pin_oe |-> rx_chain_enable) else $error("data pin driven outside rx");
    clk_pin_a: assert property (irq1_pin_oe |-> data_pin_oe) else $error("clock pin outside continuous");
    fifo_path_a: assert property (fifo_bit_valid |-> rx_chain_enable && !data_pin_oe)
        else $error("fifo bit on wrong path");
    fifo_gap_a: assert property (fifo_bit_valid |=> !fifo_bit_valid [*8]) else $error("fifo bits too close");
endmodule // oss_props

// ---- sim/oss_mcu.sv ----
/* companion microcontroller model: takes data on the recovered clock.
   assumes resolved pin levels from the bench; pulls irq1 low on command. */
`timescale 1ns/1ns
module oss_mcu (
    input wire clk,
    input wire arst_n,
    input wire data_pin,
    input wire recovered_data_clock_pin,
    input wire hold_low,
    output reg drive_out,
    output reg drive_oe,
    output reg [15:0] rise_count,
    output reg last_bit
);
    reg recovered_data_clock_q;
    // hold irq1 low when asked, count clock rises and take the bit
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_out <= 1'b0;
            drive_oe <= 1'b0;
            recovered_data_clock_q <= 1'b0;
            rise_count <= 16'h0000;
            last_bit <= 1'b0;
        end else begin
            drive_out <= 1'b0;
            drive_oe <= hold_low;
            recovered_data_clock_q <= recovered_data_clock_pin;
            if (recovered_data_clock_pin && !recovered_data_clock_q) begin
                rise_count <= rise_count + 16'h0001;
                last_bit <= data_pin;
            end
        end
    end
endmodule // oss_mcu

// ---- sim/tb.sv ----
/* self-checking bench for oss_top over apb with a companion model.
   assumes the 25 MHz clock and strength samples every 4 clocks. */
`timescale 1ns/1ns
`include "oss_regs.vh"
module tb;
    logic clk, arst_n, psel, penable, pwrite, sample_valid, hold, alt, tog, fsk;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [7:0] sample_in, lvl, phase;
    wire [31:0] prdata;
    wire [15:0] rises;
    wire pready, pslverr, data_pin_out, data_pin_oe, irq1_pin_out, irq1_pin_oe, fifo_bit_valid, rx_chain_enable;
    wire mcu_out, mcu_oe, irq1_wire, data_wire;
    integer err_count, total_checks, fcnt, i, n0;
    // released irq1 rests at its pull-up; undriven data pin toggles
    assign irq1_wire = irq1_pin_oe ? irq1_pin_out : (mcu_oe ? mcu_out : 1'b1);
    assign data_wire = data_pin_oe ? data_pin_out : tog;
    oss_top #(.SW(8)) uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_in(sample_in), .sample_valid(sample_valid), .fsk_bit_in(fsk), .irq1_pin_in(irq1_wire),
        .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .irq1_pin_out(irq1_pin_out),
        .irq1_pin_oe(irq1_pin_oe), .fifo_bit(), .fifo_bit_valid(fifo_bit_valid), .rx_chain_enable(rx_chain_enable));
    oss_mcu mcu (.clk(clk), .arst_n(arst_n), .data_pin(data_wire), .recovered_data_clock_pin(irq1_wire), .hold_low(hold),
        .drive_out(mcu_out), .drive_oe(mcu_oe), .rise_count(rises), .last_bit());
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // strength samples; alt gives 64-clock alternating bits as preamble
    always @(posedge clk) begin
        phase <= phase + 8'h01;
        tog <= ~tog;
        sample_valid <= (phase[1:0] == 2'h3);
        sample_in <= (alt && phase[6]) ? 8'h00 : lvl;
        if (fifo_bit_valid === 1'b1) fcnt = fcnt + 1;
    end
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        integer n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            n = 0;
            while (pready !== 1'b1 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n >= 50) begin
                err_count = err_count + 1;
                summarize;
            end
            @(posedge clk);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h00000000, q, e);
        chk(nm, x, q);
        chk("pslverr", {31'h0, xe}, {31'h0, e});
    endtask
    // read status until the masked field matches, bounded
    task poll(input string nm, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        integer n;
        begin
            n = 0;
            q = 32'h00000000;
            while ((q & m) !== x && n < 500) begin
                apb(1'b0, `OSS_ADDR_STATUS, 32'h00000000, q, e);
                n = n + 1;
            end
            chk(nm, x, q & m);
            if ((q & m) !== x) summarize;
        end
    endtask
    task wait_pin(input logic v);
        integer n;
        begin
            n = 0;
            while (data_pin_out !== v && n < 3000) begin
                @(posedge clk);
                n = n + 1;
            end
            chk("data_pin", {31'h0, v}, {31'h0, data_pin_out});
            if (n >= 3000) summarize;
        end
    endtask
    initial begin
        {psel, penable, pwrite, sample_valid, hold, alt, tog, fsk} = 8'h00;
        {paddr, pwdata, sample_in, lvl, phase} = 68'h0;
        {err_count, total_checks, fcnt} = 96'h0;
        arst_n = 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd("state", `OSS_ADDR_STATE, 32'h00000301, 1'b0);
        rd("slice", `OSS_ADDR_SLICE, 32'h000C0008, 1'b0);
        rd("rate", `OSS_ADDR_RATE, 32'h00000007, 1'b0);
        rd("unmapped", 12'h010, 32'h00000000, 1'b1);
        for (i = 0; i < 5; i = i + 1) begin
            wr(`OSS_ADDR_STATE, 32'h00000300 | i);
            @(posedge clk);
            chk("rx_en", {31'h0, i == 3}, {31'h0, rx_chain_enable});
        end
        $display("test states done");
        wr(`OSS_ADDR_RATE, 32'h00000000);
        wr(`OSS_ADDR_SLICE, 32'h00200009);
        wr(`OSS_ADDR_STATE, 32'h00010303);
        hold <= 1'b1;
        lvl <= 8'h40;
        wait_pin(1'b1);
        poll("thr_fixed", 32'h00FF0000, 32'h00200000);
        chk("clk_oe", 32'h0, {31'h0, irq1_pin_oe});
        lvl <= 8'h10;
        wait_pin(1'b0);
        $display("test fixed done");
        wr(`OSS_ADDR_SLICE, 32'h00200001);
        fsk <= 1'b1;
        wait_pin(1'b1);
        fsk <= 1'b0;
        wait_pin(1'b0);
        $display("test fsk raw done");
        hold <= 1'b0;
        wr(`OSS_ADDR_STATE, 32'h00000303);
        wr(`OSS_ADDR_SLICE, 32'h000C7708);
        lvl <= 8'h80;
        poll("thr_peak", 32'h00FF00FF, 32'h00740080);
        chk("clk_oe", 32'h1, {31'h0, irq1_pin_oe});
        n0 = rises;
        repeat (640) @(posedge clk);
        chk("recovered_data_clock_rises", 32'd10, rises - n0);
        lvl <= 8'h00;
        poll("thr_floor", 32'h00FF0000, 32'h000C0000);
        repeat (200) @(posedge clk);
        poll("thr_clamp", 32'h00FF0000, 32'h000C0000);
        $display("test peak done");
        wr(`OSS_ADDR_SLICE, 32'h000C000A);
        lvl <= 8'h67;
        poll("thr_avg", 32'h00F00000, 32'h00600000);
        $display("test average done");
        alt <= 1'b1;
        lvl <= 8'h80;
        for (i = 1; i < 4; i = i + 1) begin
            wr(`OSS_ADDR_STATE, 32'h00010303 | (i << 4));
            repeat (640) @(posedge clk);
            n0 = fcnt;
            repeat (640) @(posedge clk);
            chk("fifo_bits", 32'd10, fcnt - n0);
            chk("data_oe", 32'h0, {31'h0, data_pin_oe});
        end
        $display("test paths done");
        summarize;
    end
endmodule // tb
bind oss_top oss_props chk (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .data_pin_oe(data_pin_oe),
    .irq1_pin_oe(irq1_pin_oe), .fifo_bit_valid(fifo_bit_valid), .rx_chain_enable(rx_chain_enable));
